// ==== design/cdt_consts.svh ====
// offsets, field positions and widths of the cache data and tag store
`ifndef CDT_CONSTS_SVH
`define CDT_CONSTS_SVH

`define CDT_INDEX_W      12
`define CDT_BUS_W        22
`define CDT_DATA_W       16
`define CDT_TAG_W        16
`define CDT_SHADOW_W     12
`define CDT_LABEL_W      9
`define CDT_LABEL_LSB    13
`define CDT_PA16         16
`define CDT_PA17         17

`define CDT_TAG_LO_PAR   9
`define CDT_TAG_HI_PAR   10
`define CDT_TAG_PAR      11
`define CDT_TAG_VALID    12
`define CDT_SH_PAR       9
`define CDT_SH_VALID     10

`define CDT_REG_CTRL     8'h00
`define CDT_REG_STATUS   8'h04
`define CDT_CTRL_RESET   1'h0

`endif

// ==== design/cdt_pkg.sv ====
// types of the cache data and tag store
package cdt_pkg;

    typedef struct packed {
        logic        hi_sel;
        logic        lo_sel;
        logic        tag_sel;
        logic        wr;
        logic        upd;
        logic [15:0] data_out;
        logic [15:0] tag_out;
        logic [11:0] shadow_out;
        logic        hi_err;
        logic        lo_err;
        logic        hi_dpar;
        logic        lo_dpar;
        logic        tag_valid;
        logic        tag_par;
        logic        sh_valid;
        logic        sh_par;
        logic        mem_hi;
        logic        mem_lo;
        logic        mem_hi_n;
        logic        mem_lo_n;
        logic        ctrl_force;
        logic        st_hi;
        logic        st_lo;
        logic        ack;
        logic [31:0] dat;
        logic        past_ok;
    } cdt_state_t;

endpackage

// ==== design/cdt_store.sv ====
// cache data ram, cache tag store and shadow (dma) tag store with parity
//
// Overview of operation
// RULE1: 8 KB data ram indexed by address bits 12:1
// RULE2: addressed word always driven; validity checked elsewhere
// RULE3: low byte read on select, written with strobe
// RULE4: high byte read on select, written with strobe
// RULE5: read data delivered on cache data bus
// RULE6: tag entry holds label, byte parities, parity, valid
// RULE7: tag low half follows low select and strobe
// RULE8: low byte parity even, high byte odd
// RULE9: byte parity checked, errors flagged per byte
// RULE10: memory parity latched on bus open, both polarities
// RULE11: nine-bit generator gives odd and even result
// RULE12: selector picks stored, predicted or wrong parity
// RULE13: parity outputs driven only during update
// RULE14: shared valid logic; shadow parity copies tag parity
// RULE15: valid true only when six conditions hold
// RULE16: shadow entry is tag entry minus byte parities
// RULE17: dma side reads shadow store by its address
// RULE18: cache select asserts all three selects
// RULE19: high request without select end selects high
// RULE20: low request without select end selects low
// RULE21: write strobe is tag write without update end
// RULE22: update strobe is request without update end
// RULE23: tag parity is even parity
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "cdt_consts.svh"

module cdt_store (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic [21:0] proc_addr_data_bus_i,
    input  wire logic [15:0] cache_data_in_i,
    input  wire logic        cache_select_all_i,
    input  wire logic        hi_byte_request_i,
    input  wire logic        lo_byte_request_i,
    input  wire logic        select_end_i,
    input  wire logic        tag_write_request_i,
    input  wire logic        update_request_i,
    input  wire logic        update_end_i,
    input  wire logic        mem_hi_parity_in_n_i,
    input  wire logic        mem_lo_parity_in_n_i,
    input  wire logic        bus_open_strobe_i,
    input  wire logic        predict_select_i,
    input  wire logic        force_bad_parity_i,
    input  wire logic        bank_select_one_i,
    input  wire logic        nonexistent_memory_i,
    input  wire logic        dma_invalidate_i,
    input  wire logic        read_cycle_flag_i,
    input  wire logic [12:0] dma_address_bus_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             hi_byte_select_o,
    output logic             lo_byte_select_o,
    output logic             tag_entry_select_o,
    output logic             cache_write_strobe_o,
    output logic             update_strobe_o,
    output logic [15:0]      cache_data_bus_o,
    output logic [15:0]      tag_entry_o,
    output logic             hi_data_parity_o,
    output logic             lo_data_parity_o,
    output logic             tag_valid_bit_o,
    output logic             tag_parity_bit_o,
    output logic             shadow_tag_valid_o,
    output logic             shadow_tag_parity_o,
    output logic [11:0]      shadow_tag_bus_o,
    output logic             hi_parity_error_o,
    output logic             lo_parity_error_o
);

    localparam int DEPTH = 1 << `CDT_INDEX_W;

    ////////////////////////////////////////////////////////////////////////
    // storage
    logic [15:0] data_ram   [DEPTH];
    logic [15:0] tag_ram    [DEPTH];
    logic [11:0] shadow_ram [DEPTH];

    cdt_pkg::cdt_state_t st;
    cdt_pkg::cdt_state_t next_st;

    logic [11:0] idx;
    logic [11:0] dma_idx;
    logic [8:0]  label;
    logic        hi_sel_c;
    logic        lo_sel_c;
    logic        wr_c;
    logic        upd_c;
    logic [15:0] rd_word;
    logic [15:0] rd_tag;
    logic [7:0]  gen_lo_byte;
    logic [7:0]  gen_hi_byte;
    logic        gen_lo_even;
    logic        gen_lo_odd;
    logic        gen_hi_even;
    logic        gen_hi_odd;
    logic        force_c;
    logic        sel_lo_par;
    logic        sel_hi_par;
    logic        valid_c;
    logic        tpar_c;
    logic [15:0] tag_wdata;
    logic        wb_req;

    assign idx     = proc_addr_data_bus_i[12:1];                       // RULE1
    assign dma_idx = dma_address_bus_i[12:1];                          // RULE17
    assign label   = proc_addr_data_bus_i[21:13];
    assign rd_word = data_ram[idx];                                    // RULE2
    assign rd_tag  = tag_ram[idx];

    ////////////////////////////////////////////////////////////////////////
    // select and strobe decode from control store phases
    assign hi_sel_c = cache_select_all_i
                    | (hi_byte_request_i & ~select_end_i);             // RULE18 RULE19
    assign lo_sel_c = cache_select_all_i
                    | (lo_byte_request_i & ~select_end_i);             // RULE18 RULE20
    assign wr_c     = tag_write_request_i & ~update_end_i;             // RULE21
    assign upd_c    = update_request_i & ~update_end_i;                // RULE22

    ////////////////////////////////////////////////////////////////////////
    // parity generation: stored bit enters only when not updating
    assign gen_lo_byte = upd_c ? cache_data_in_i[7:0]  : rd_word[7:0];
    assign gen_hi_byte = upd_c ? cache_data_in_i[15:8] : rd_word[15:8];
    assign gen_lo_even = ^{gen_lo_byte, rd_tag[`CDT_TAG_LO_PAR] & ~upd_c}; // RULE11
    assign gen_lo_odd  = ~gen_lo_even;                                     // RULE11
    assign gen_hi_even = ^{gen_hi_byte, rd_tag[`CDT_TAG_HI_PAR] & ~upd_c}; // RULE11
    assign gen_hi_odd  = ~gen_hi_even;                                     // RULE11

    // software can force bad parity as well as the control pin
    assign force_c = force_bad_parity_i | st.ctrl_force;

    // predicted: low even, high odd; wrong copies are the inverses
    always_comb begin
        case ({predict_select_i, force_c})                             // RULE12
            2'h0:    sel_lo_par = st.mem_lo;
            2'h1:    sel_lo_par = st.mem_lo_n;
            2'h2:    sel_lo_par = gen_lo_even;                         // RULE8
            2'h3:    sel_lo_par = gen_lo_odd;
            default: sel_lo_par = 1'h0;
        endcase
        case ({predict_select_i, force_c})                             // RULE12
            2'h0:    sel_hi_par = st.mem_hi;
            2'h1:    sel_hi_par = st.mem_hi_n;
            2'h2:    sel_hi_par = gen_hi_odd;                          // RULE8
            2'h3:    sel_hi_par = gen_hi_even;
            default: sel_hi_par = 1'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // tag valid and tag parity
    assign valid_c = ~bank_select_one_i                                // RULE15
                   & ~nonexistent_memory_i & ~dma_invalidate_i
                   & (~bus_open_strobe_i | ~proc_addr_data_bus_i[`CDT_PA17]
                      | ~proc_addr_data_bus_i[`CDT_PA16])
                   & ~predict_select_i & ~read_cycle_flag_i;
    assign tpar_c  = ^{label, valid_c};                                // RULE23

    always_comb begin
        tag_wdata                  = 16'h0000;                         // RULE6
        tag_wdata[8:0]             = label;
        tag_wdata[`CDT_TAG_LO_PAR] = sel_lo_par;
        tag_wdata[`CDT_TAG_HI_PAR] = sel_hi_par;
        tag_wdata[`CDT_TAG_PAR]    = tpar_c;
        tag_wdata[`CDT_TAG_VALID]  = valid_c;
    end

    ////////////////////////////////////////////////////////////////////////
    // ram writes: each byte half needs its select plus the strobe
    always_ff @(posedge clk_sys_i) begin
        if (wr_c && lo_sel_c) begin
            data_ram[idx][7:0] <= cache_data_in_i[7:0];                // RULE3
            tag_ram[idx][7:0]  <= tag_wdata[7:0];                      // RULE7
        end
        if (wr_c && hi_sel_c) begin
            data_ram[idx][15:8] <= cache_data_in_i[15:8];              // RULE4
            tag_ram[idx][15:8]  <= tag_wdata[15:8];
        end
        if (wr_c && (hi_sel_c || lo_sel_c)) begin
            shadow_ram[idx] <= {1'h0, valid_c, tpar_c, label};         // RULE16
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    assign wb_req = wb_cyc_i & wb_stb_i & ~st.ack;

    always_comb begin
        next_st            = st;
        next_st.past_ok    = 1'h1;
        next_st.hi_sel     = hi_sel_c;
        next_st.lo_sel     = lo_sel_c;
        next_st.tag_sel    = hi_sel_c | lo_sel_c;                      // RULE18
        next_st.wr         = wr_c;
        next_st.upd        = upd_c;
        next_st.hi_err     = 1'h0;
        next_st.lo_err     = 1'h0;
        if (lo_sel_c) begin
            next_st.data_out[7:0] = rd_word[7:0];                      // RULE3 RULE5
            next_st.tag_out[7:0]  = rd_tag[7:0];                       // RULE7
            next_st.lo_err = ^{rd_word[7:0], rd_tag[`CDT_TAG_LO_PAR]}; // RULE9
        end
        if (hi_sel_c) begin
            next_st.data_out[15:8] = rd_word[15:8];                    // RULE4 RULE5
            next_st.tag_out[15:8]  = rd_tag[15:8];
            next_st.hi_err = ~^{rd_word[15:8], rd_tag[`CDT_TAG_HI_PAR]}; // RULE9
        end
        next_st.shadow_out = shadow_ram[dma_idx];                      // RULE17
        // parity and valid outputs are quiet outside the update strobe
        next_st.hi_dpar    = upd_c & sel_hi_par;                       // RULE13
        next_st.lo_dpar    = upd_c & sel_lo_par;                       // RULE13
        next_st.tag_valid  = upd_c & valid_c;                          // RULE14
        next_st.tag_par    = upd_c & tpar_c;
        next_st.sh_valid   = upd_c & valid_c;                          // RULE14
        next_st.sh_par     = upd_c & tpar_c;                           // RULE14
        if (bus_open_strobe_i) begin
            next_st.mem_hi   = ~mem_hi_parity_in_n_i;                  // RULE10
            next_st.mem_lo   = ~mem_lo_parity_in_n_i;
            next_st.mem_hi_n = mem_hi_parity_in_n_i;                   // RULE10
            next_st.mem_lo_n = mem_lo_parity_in_n_i;
        end
        // ack one cycle after the request; a write lands on the edge that sees ack
        next_st.ack = wb_req;
        next_st.dat = 32'h0000_0000;
        if (st.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `CDT_REG_CTRL) begin
                next_st.ctrl_force = wb_dat_i[0];
            end
            if (wb_adr_i == `CDT_REG_STATUS) begin
                next_st.st_hi = st.st_hi & ~wb_dat_i[0];
                next_st.st_lo = st.st_lo & ~wb_dat_i[1];
            end
        end
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `CDT_REG_CTRL:   next_st.dat = {31'h0, st.ctrl_force};
                `CDT_REG_STATUS: next_st.dat = {28'h0, st.mem_lo, st.mem_hi,
                                                st.st_lo, st.st_hi};
                default:         next_st.dat = 32'h0000_0000;
            endcase
        end
        // a new error beats a clear in the same cycle
        if (next_st.hi_err) begin
            next_st.st_hi = 1'h1;
        end
        if (next_st.lo_err) begin
            next_st.st_lo = 1'h1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st            <= '0;
            st.ctrl_force <= `CDT_CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign wb_dat_o             = st.dat;
    assign wb_ack_o             = st.ack;
    assign hi_byte_select_o     = st.hi_sel;
    assign lo_byte_select_o     = st.lo_sel;
    assign tag_entry_select_o   = st.tag_sel;
    assign cache_write_strobe_o = st.wr;
    assign update_strobe_o      = st.upd;
    assign cache_data_bus_o     = st.data_out;
    assign tag_entry_o          = st.tag_out;
    assign hi_data_parity_o     = st.hi_dpar;
    assign lo_data_parity_o     = st.lo_dpar;
    assign tag_valid_bit_o      = st.tag_valid;
    assign tag_parity_bit_o     = st.tag_par;
    assign shadow_tag_valid_o   = st.sh_valid;
    assign shadow_tag_parity_o  = st.sh_par;
    assign shadow_tag_bus_o     = st.shadow_out;
    assign hi_parity_error_o    = st.hi_err;
    assign lo_parity_error_o    = st.lo_err;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_lo_write;
        lo_sel_c && wr_c;
    endsequence

    sequence s_lo_read_same;
        lo_sel_c && !wr_c && idx == $past(idx);
    endsequence

    sequence s_hi_write;
        hi_sel_c && wr_c;
    endsequence

    sequence s_hi_read_same;
        hi_sel_c && !wr_c && idx == $past(idx);
    endsequence

    chk_all_select: assert property (                                  // RULE18
        cache_select_all_i |=> hi_byte_select_o && lo_byte_select_o
                               && tag_entry_select_o)
        else $error("cache select did not raise all selects");

    chk_hi_select: assert property (                                   // RULE19
        hi_byte_request_i && !select_end_i |=> hi_byte_select_o && tag_entry_select_o)
        else $error("high byte select missing");

    chk_lo_select: assert property (                                   // RULE20
        !cache_select_all_i && select_end_i |=> !lo_byte_select_o && !hi_byte_select_o)
        else $error("select asserted during select end");

    chk_write_strobe: assert property (                                // RULE21
        st.past_ok |-> cache_write_strobe_o ==
                       ($past(tag_write_request_i) && !$past(update_end_i)))
        else $error("write strobe does not follow request");

    chk_update_strobe: assert property (                               // RULE22
        update_end_i |=> !update_strobe_o)
        else $error("update strobe during update end");

    chk_par_quiet: assert property (                                   // RULE13
        !update_strobe_o |-> !hi_data_parity_o && !lo_data_parity_o
                             && !tag_valid_bit_o)
        else $error("parity driven outside update");

    chk_shadow_copy: assert property (                                 // RULE14
        shadow_tag_parity_o == tag_parity_bit_o
        && shadow_tag_valid_o == tag_valid_bit_o)
        else $error("shadow valid or parity differs");

    chk_valid_bank: assert property (                                  // RULE15
        bank_select_one_i || read_cycle_flag_i |=> !tag_valid_bit_o)
        else $error("valid set despite blocking condition");

    chk_mem_latch: assert property (                                   // RULE10
        bus_open_strobe_i |=> st.mem_lo == !$past(mem_lo_parity_in_n_i)
                              && st.mem_lo_n == !st.mem_lo)
        else $error("memory parity not latched");

    chk_lo_roundtrip: assert property (                                // RULE3
        s_lo_write ##1 s_lo_read_same |=>
            cache_data_bus_o[7:0] == $past(cache_data_in_i[7:0], 2))
        else $error("low byte read back wrong");

    chk_tag_even: assert property (                                    // RULE23
        update_strobe_o |-> ^{tag_parity_bit_o, $past(label), tag_valid_bit_o} == 1'b0)
        else $error("tag parity not even");

    chk_hi_roundtrip: assert property (                                // RULE4
        s_hi_write ##1 s_hi_read_same |=>
            cache_data_bus_o[15:8] == $past(cache_data_in_i[15:8], 2))
        else $error("high byte read back wrong");

    chk_err_quiet: assert property (                                   // RULE9
        !lo_sel_c && !hi_sel_c |=> !lo_parity_error_o && !hi_parity_error_o)
        else $error("parity error without access");

    chk_update_on: assert property (                                   // RULE22
        update_request_i && !update_end_i |=> update_strobe_o)
        else $error("update strobe missing");

    chk_err_sticky: assert property (                                  // RULE9
        (!hi_parity_error_o || st.st_hi) && (!lo_parity_error_o || st.st_lo))
        else $error("parity error not recorded");

endmodule // cdt_store

// ==== sim/cdt_mem_model.sv ====
// main-memory side model: supplies active-low byte parity during fills
`timescale 1ns/1ps

module cdt_mem_model (
    input  wire logic        clk_sys_i,
    input  wire logic        drive_i,
    input  wire logic [15:0] fill_data_i,
    output logic             mem_hi_n_o,
    output logic             mem_lo_n_o
);
    logic hold_hi = 1'b0;
    logic hold_lo = 1'b0;
    logic hi_now;
    logic lo_now;

    // true parity: low byte even, high byte odd; pins are active low
    assign hi_now = ~(~^fill_data_i[15:8]);
    assign lo_now = ~(^fill_data_i[7:0]);

    always @(posedge clk_sys_i) begin
        if (drive_i) begin
            {hold_hi, hold_lo} <= {hi_now, lo_now};
        end
    end

    // released pins show the inverse of the last value, so a stale latch is caught
    assign mem_hi_n_o = drive_i ? hi_now : ~hold_hi;
    assign mem_lo_n_o = drive_i ? lo_now : ~hold_lo;
endmodule // cdt_mem_model

// ==== sim/tb.sv ====
// self-checking bench for the cache data and tag store
`timescale 1ns/1ps

module tb;
    logic        clk, rst, csa, hreq, lreq, send, twr, ureq, uend, bopen, mhi_n, mlo_n;
    logic        pred, frc, bank1, nxm, dinv, rdf, cyc, stb, we;
    logic        ack, hs, ls, ts, wrs, ups, hdp, ldp, tv, tp, sv, sp, herr, lerr;
    logic [21:0] addr;
    logic [15:0] din, cdb, tage;
    logic [12:0] dma_address_bus;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [11:0] shb;
    logic [11:0] idx_q [6] = '{12'h000, 12'hfff, 12'h800, 12'h001, 12'h555, 12'haaa};
    logic [15:0] dat_q [6];
    logic [15:0] tag_q [6];
    logic        bad_q [6];
    int          err_count, checked, cycles, seed;

    cdt_store uut (
        .clk_sys_i(clk), .rst_i(rst), .proc_addr_data_bus_i(addr), .cache_data_in_i(din),
        .cache_select_all_i(csa), .hi_byte_request_i(hreq), .lo_byte_request_i(lreq),
        .select_end_i(send), .tag_write_request_i(twr), .update_request_i(ureq),
        .update_end_i(uend), .mem_hi_parity_in_n_i(mhi_n), .mem_lo_parity_in_n_i(mlo_n),
        .bus_open_strobe_i(bopen), .predict_select_i(pred), .force_bad_parity_i(frc),
        .bank_select_one_i(bank1), .nonexistent_memory_i(nxm), .dma_invalidate_i(dinv),
        .read_cycle_flag_i(rdf), .dma_address_bus_i(dma_address_bus), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .hi_byte_select_o(hs), .lo_byte_select_o(ls),
        .tag_entry_select_o(ts), .cache_write_strobe_o(wrs), .update_strobe_o(ups),
        .cache_data_bus_o(cdb), .tag_entry_o(tage), .hi_data_parity_o(hdp),
        .lo_data_parity_o(ldp), .tag_valid_bit_o(tv), .tag_parity_bit_o(tp),
        .shadow_tag_valid_o(sv), .shadow_tag_parity_o(sp), .shadow_tag_bus_o(shb),
        .hi_parity_error_o(herr), .lo_parity_error_o(lerr)
    );

    cdt_mem_model mem (
        .clk_sys_i(clk), .drive_i(bopen), .fill_data_i(din),
        .mem_hi_n_o(mhi_n), .mem_lo_n_o(mlo_n)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        q = rdat;
        {cyc, stb, we} <= 3'b000;
        cmp_word(n, 32'h2, "bus ack latency");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic decode_check();
        logic [6:0] r;
        logic       eh, el, up;
        r = 7'($random(seed));
        @(posedge clk);
        {csa, hreq, lreq, send, twr, ureq, uend} <= r;
        din <= 16'($random(seed));
        @(posedge clk);
        #1;
        eh = r[6] | (r[5] & ~r[3]);
        el = r[6] | (r[4] & ~r[3]);
        up = r[1] & ~r[0];
        cmp_bit(hs, eh, "hi select");
        cmp_bit(ls, el, "lo select");
        cmp_bit(ts, eh | el, "tag select");
        cmp_bit(wrs, r[2] & ~r[0], "write strobe");
        cmp_bit(ups, up, "update strobe");
        if (!up) cmp_word({hdp, ldp, tv, sv}, 4'h0, "outputs idle");
    endtask

    task automatic fill(input int k, input logic p, input logic f, input logic ctl);
        logic [8:0] lab;
        logic [3:0] c;
        logic       v, tpar, eh, el;
        lab = 9'($random(seed));
        c = 4'($random(seed)) & 4'($random(seed));
        if (k == 4) {c, lab[4]} = 5'h00;
        dat_q[k] = 16'($random(seed));
        bad_q[k] = f | ctl;
        @(posedge clk);
        {addr, din, bopen, pred, frc, bank1, nxm, dinv, rdf, csa, send, uend} <=
            {lab, idx_q[k], 1'b0, dat_q[k], 1'b1, p, f, c, 3'b000};
        @(posedge clk);
        {hreq, lreq, twr, ureq} <= 4'hf;
        @(posedge clk);
        {hreq, lreq, twr, ureq, bopen} <= 5'h00;
        #1;
        // bus open stays high here, so address bits 17 and 16 (label bits 4 and 3) both set must drop valid
        v = ~|c & ~p & ~(lab[4] & lab[3]);
        tpar = ^{lab, v};
        eh = ~^dat_q[k][15:8] ^ bad_q[k];
        el = ^dat_q[k][7:0] ^ bad_q[k];
        tag_q[k] = {3'b000, v, tpar, eh, el, lab};
        cmp_word({hs, ls, ts, wrs, ups}, 5'h1f, "fill strobes");
        cmp_bit(hdp, eh, "hi parity out");
        cmp_bit(ldp, el, "lo parity out");
        cmp_bit(tv, v, "tag valid");
        cmp_bit(tp, tpar, "tag parity");
        cmp_word({sv, sp}, {v, tpar}, "shadow valid and parity");
    endtask

    task automatic rd(input int k);
        @(posedge clk);
        {addr[12:1], hreq, lreq, dma_address_bus} <= {idx_q[k], 2'b11, idx_q[k], 1'b0};
        @(posedge clk);
        {hreq, lreq} <= 2'b00;
        #1;
        cmp_word(cdb, dat_q[k], "read data");
        cmp_word(tage, tag_q[k], "tag entry");
        cmp_bit(herr, bad_q[k], "hi parity error");
        cmp_bit(lerr, bad_q[k], "lo parity error");
        @(posedge clk);
        #1;
        cmp_word(shb, {1'b0, tag_q[k][12:11], tag_q[k][8:0]}, "shadow entry");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hcef28697;
        {csa, hreq, lreq, send, twr, ureq, uend, bopen, pred, frc} = 10'h000;
        {bank1, nxm, dinv, rdf, cyc, stb, we, addr, din, dma_address_bus} = 'h0;
        {adr, sel, wdat} = 'h0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        cmp_word({cdb, tage}, 32'h0, "outputs in reset");
        cmp_word({shb, ups, ack}, 32'h0, "outputs in reset");
        rst <= 1'b0;
        wb(1'b0, 8'h00, 32'h0);
        cmp_word(q, 32'h0, "control reset value");
        wb(1'b1, 8'h08, 32'hffff_ffff);
        wb(1'b0, 8'h08, 32'h0);
        cmp_word(q, 32'h0, "unmapped read");
        repeat (60) decode_check();
        // every selector code: {predict, force} 00, 01, 10, 11
        for (int k = 0; k < 4; k++) fill(k, k[1], k[0], 1'b0);
        fill(4, 1'b0, 1'b0, 1'b0);
        wb(1'b1, 8'h00, 32'h1);
        fill(5, 1'b1, 1'b0, 1'b1);
        wb(1'b1, 8'h00, 32'h0);
        for (int k = 0; k < 6; k++) rd(k);
        wb(1'b0, 8'h04, 32'h0);
        cmp_word({30'h0, q[1:0]}, 32'h3, "sticky errors");
        cmp_word(q[3:2], {^dat_q[5][7:0], ~^dat_q[5][15:8]}, "latched memory parity");
        wb(1'b1, 8'h04, 32'h3);
        wb(1'b0, 8'h04, 32'h0);
        cmp_word({30'h0, q[1:0]}, 32'h0, "sticky errors cleared");
        tally_and_finish();
    end
endmodule // tb
